/* hw/pin_match_pkg.sv */
// Purpose: constants and types for the pin interrupt and pattern match block
// Assumes: one 250 MHz clock, Avalon-MM register access, 32-bit words
// Notes:   register offsets are byte addresses
//
// Function
// - eight selected inputs, one request each
// - edge sense on rise, fall or both
// - level sense, request while at active level
// - channels and slices share request lines 0..7
// - pattern engine uses same eight inputs
// - slice has input mux and detect logic
// - endpoint slice asserts when whole term true
// - sticky edge stays high until cleared
// - event mode pulses one cycle per edge
// - level mode high while input at level
// - continuous evaluation, one request per term
// - receive event is OR of terms
// - match pin carries same ORed signal
// - one bit selects pin or term requests
// - receive event works in pin mode too
// - only pin requests serve as wake-up
// - mode bit 0 edge, 1 level
// - second enable is fall enable or polarity
// - edges always recorded, write one clears
package pin_match_pkg;

	localparam int NCH = 8;
	localparam int SEL_W = 3;

	//--------------------------------------------------
	// Register offsets
	//--------------------------------------------------
	localparam logic [5:0] OFF_SENSE_MODE   = 6'h00;
	localparam logic [5:0] OFF_RISE_EN      = 6'h04;
	localparam logic [5:0] OFF_RISE_EN_SET  = 6'h08;
	localparam logic [5:0] OFF_RISE_EN_CLR  = 6'h0C;
	localparam logic [5:0] OFF_FALL_EN      = 6'h10;
	localparam logic [5:0] OFF_FALL_EN_SET  = 6'h14;
	localparam logic [5:0] OFF_FALL_EN_CLR  = 6'h18;
	localparam logic [5:0] OFF_RISE_FLAG    = 6'h1C;
	localparam logic [5:0] OFF_FALL_FLAG    = 6'h20;
	localparam logic [5:0] OFF_STATUS       = 6'h24;
	localparam logic [5:0] OFF_MATCH_CTRL   = 6'h28;
	localparam logic [5:0] OFF_SLICE_SRC    = 6'h2C;
	localparam logic [5:0] OFF_SLICE_CFG    = 6'h30;

	//--------------------------------------------------
	// Field layout and reset values
	//--------------------------------------------------
	localparam int CTRL_SEL_MATCH   = 0;
	localparam int CTRL_EVENT_EN    = 1;
	localparam int CTRL_DET_LSB     = 24;
	localparam int SLICE_LSB        = 8;
	localparam int EP_W             = 7;
	localparam logic [7:0]  RST8    = 8'h00;
	localparam logic [23:0] RST24   = 24'h000000;
	localparam logic [31:0] RST32   = 32'h00000000;

	typedef enum logic [2:0] {
		COND_ALWAYS      = 3'h0,
		COND_STICKY_RISE = 3'h1,
		COND_STICKY_FALL = 3'h2,
		COND_STICKY_BOTH = 3'h3,
		COND_LEVEL_HIGH  = 3'h4,
		COND_LEVEL_LOW   = 3'h5,
		COND_NEVER       = 3'h6,
		COND_EVENT_BOTH  = 3'h7
	} slice_cond_t;

endpackage

/* hw/pin_event_if.sv */
// Purpose: carries synchronised levels and edge pulses of the inputs
// Assumes: single clock domain
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
interface pin_event_if #(parameter int W = 8);
	logic [W-1:0] level;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	modport src (output level, output rise, output fall);
	modport snk (input level, input rise, input fall);
endinterface
`default_nettype wire

/* hw/input_edge_sync.sv */
// Purpose: two-flop synchroniser and edge detector per input
// Assumes: inputs asynchronous to i_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module input_edge_sync #(
	parameter int W = 8
) (
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	input  wire logic [W-1:0] i_pins,
	pin_event_if.src          evt
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	if (W < 1) begin : g_bad
		$error("input_edge_sync: W must be at least 1");
	end

	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = i_pins;
		s_nxt.sync = s_r.meta;
		s_nxt.prev = s_r.sync;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign evt.level = s_r.sync;
	assign evt.rise  = s_r.sync & ~s_r.prev;
	assign evt.fall  = ~s_r.sync & s_r.prev;

endmodule
`default_nettype wire

/* hw/match_slice.sv */
// Purpose: one pattern match bit slice: input mux and detect logic
// Assumes: event pulses from input_edge_sync
// Notes:   clear wins only when no new edge arrives
`timescale 1ns/100ps
`default_nettype none
module match_slice #(
	parameter int W = 8
) (
	input  wire logic                      i_clk,
	input  wire logic                      i_reset,
	pin_event_if.snk                       evt,
	input  wire logic [$clog2(W)-1:0]      i_src,
	input  wire pin_match_pkg::slice_cond_t i_cond,
	input  wire logic                      i_clear,
	output logic                           o_detect
);

	typedef struct packed {
		logic det;
	} slice_state_t;

	slice_state_t s_r;
	slice_state_t s_nxt;

	if (W < 2) begin : g_bad
		$error("match_slice: W must be at least 2");
	end

	always_comb begin
		logic lv;
		logic rs;
		logic fl;
		lv    = evt.level[i_src];
		rs    = evt.rise[i_src];
		fl    = evt.fall[i_src];
		s_nxt = s_r;
		case (i_cond)
			pin_match_pkg::COND_ALWAYS:      s_nxt.det = 1'b1;
			pin_match_pkg::COND_STICKY_RISE: s_nxt.det = (s_r.det & ~i_clear) | rs;
			pin_match_pkg::COND_STICKY_FALL: s_nxt.det = (s_r.det & ~i_clear) | fl;
			pin_match_pkg::COND_STICKY_BOTH: s_nxt.det = (s_r.det & ~i_clear) | rs | fl;
			pin_match_pkg::COND_LEVEL_HIGH:  s_nxt.det = lv;
			pin_match_pkg::COND_LEVEL_LOW:   s_nxt.det = ~lv;
			pin_match_pkg::COND_EVENT_BOTH:  s_nxt.det = rs | fl;
			default:                         s_nxt.det = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_detect = s_r.det;

endmodule
`default_nettype wire

/* hw/pin_match_engine.sv */
// Purpose: eight-channel pin interrupt and pattern match engine
// Assumes: Avalon-MM slave, byte addresses, synchronous reset
// Notes:   every output comes from a flip-flop
`timescale 1ns/100ps
`default_nettype none
module pin_match_engine #(
	parameter int N_IN = 8
) (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic [7:0]  i_pins,
	input  wire logic [5:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic [7:0]       o_irq,
	output logic [7:0]       o_wake,
	output logic             o_receive_event_out,
	output logic             o_match_output_pin
);

	//--------------------------------------------------
	// Elaboration check
	//--------------------------------------------------
	if (N_IN != pin_match_pkg::NCH) begin : g_bad
		$error("pin_match_engine: N_IN must be 8");
	end

	//--------------------------------------------------
	// State
	//--------------------------------------------------
	typedef struct packed {
		logic [7:0]  channel_sense_mode;
		logic [7:0]  rise_or_level_enable;
		logic [7:0]  fall_or_level_polarity_enable;
		logic [7:0]  rise_flag;
		logic [7:0]  fall_flag;
		logic        sel_match;
		logic        event_en;
		logic [23:0] slice_source_select;
		logic [31:0] slice_condition_config;
		logic        slice_clr;
		logic        waitreq;
		logic [31:0] rdata;
		logic [7:0]  irq;
		logic [7:0]  wake;
		logic        rx_event;
		logic        match_pin;
	} eng_state_t;

	eng_state_t s_r;
	eng_state_t s_nxt;

	logic [7:0] det;

	//--------------------------------------------------
	// Input sync and slices
	//--------------------------------------------------
	pin_event_if #(.W(8)) evt ();

	input_edge_sync #(
		.W (8)
	) u_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_pins  (i_pins),
		.evt     (evt.src)
	);

	for (genvar g = 0; g < 8; g++) begin : g_slice
		match_slice #(
			.W (8)
		) u_slice (
			.i_clk    (i_clk),
			.i_reset  (i_reset),
			.evt      (evt.snk),
			.i_src    (s_r.slice_source_select[3*g +: 3]),
			.i_cond   (pin_match_pkg::slice_cond_t'(
			             s_r.slice_condition_config[pin_match_pkg::SLICE_LSB + 3*g +: 3])),
			.i_clear  (s_r.slice_clr),
			.o_detect (det[g])
		);
	end

	//--------------------------------------------------
	// Byte lane merge
	//--------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [3:0]  be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	//--------------------------------------------------
	// Next state
	//--------------------------------------------------
	always_comb begin
		logic        req;
		logic        wr;
		logic        lo;
		logic [7:0]  wd;
		logic [7:0]  pin_req;
		logic [7:0]  ep;
		logic [7:0]  term;
		logic        chain;
		logic        acc;
		logic [7:0]  rclr;
		logic [7:0]  fclr;
		logic [31:0] tmp;
		req     = i_avs_read | i_avs_write;
		wr      = i_avs_write & ~s_r.waitreq;
		lo      = i_avs_byteenable[0];
		wd      = i_avs_writedata[7:0];
		rclr    = 8'h00;
		fclr    = 8'h00;
		tmp     = 32'h00000000;
		term    = 8'h00;
		chain   = 1'b1;
		acc     = 1'b0;
		s_nxt   = s_r;

		// Pin interrupt requests
		pin_req = (s_r.channel_sense_mode & s_r.rise_or_level_enable
		           & ~(evt.level ^ s_r.fall_or_level_polarity_enable))
		        | (~s_r.channel_sense_mode & ((s_r.rise_flag & s_r.rise_or_level_enable)
		           | (s_r.fall_flag & s_r.fall_or_level_polarity_enable)));

		// Product terms
		ep = {1'b1, s_r.slice_condition_config[pin_match_pkg::EP_W-1:0]};
		for (int i = 0; i < 8; i++) begin
			acc     = chain & det[i];
			term[i] = acc & ep[i];
			chain   = ep[i] ? 1'b1 : acc;
		end

		// Bus handshake
		s_nxt.waitreq   = ~(req & s_r.waitreq);
		s_nxt.slice_clr = 1'b0;

		// Register writes
		if (wr && lo) begin
			case (i_avs_address)
				pin_match_pkg::OFF_SENSE_MODE:  s_nxt.channel_sense_mode = wd;
				pin_match_pkg::OFF_RISE_EN:     s_nxt.rise_or_level_enable = wd;
				pin_match_pkg::OFF_RISE_EN_SET: s_nxt.rise_or_level_enable = s_r.rise_or_level_enable | wd;
				pin_match_pkg::OFF_RISE_EN_CLR: s_nxt.rise_or_level_enable = s_r.rise_or_level_enable & ~wd;
				pin_match_pkg::OFF_FALL_EN:     s_nxt.fall_or_level_polarity_enable = wd;
				pin_match_pkg::OFF_FALL_EN_SET:
					s_nxt.fall_or_level_polarity_enable = s_r.fall_or_level_polarity_enable | wd;
				pin_match_pkg::OFF_FALL_EN_CLR:
					s_nxt.fall_or_level_polarity_enable = s_r.fall_or_level_polarity_enable & ~wd;
				pin_match_pkg::OFF_RISE_FLAG:   rclr = wd;
				pin_match_pkg::OFF_FALL_FLAG:   fclr = wd;
				pin_match_pkg::OFF_STATUS: begin
					rclr = wd & ~s_r.channel_sense_mode;
					fclr = wd & ~s_r.channel_sense_mode;
					s_nxt.fall_or_level_polarity_enable =
						s_r.fall_or_level_polarity_enable ^ (wd & s_r.channel_sense_mode);
				end
				pin_match_pkg::OFF_MATCH_CTRL: begin
					s_nxt.sel_match = wd[pin_match_pkg::CTRL_SEL_MATCH];
					s_nxt.event_en  = wd[pin_match_pkg::CTRL_EVENT_EN];
				end
				default: begin
				end
			endcase
		end
		if (wr && i_avs_address == pin_match_pkg::OFF_SLICE_SRC) begin
			tmp = merge({s_r.slice_source_select, 8'h00}, i_avs_writedata, i_avs_byteenable);
			s_nxt.slice_source_select = tmp[31:8];
			s_nxt.slice_clr = 1'b1;
		end
		if (wr && i_avs_address == pin_match_pkg::OFF_SLICE_CFG) begin
			s_nxt.slice_condition_config = merge(s_r.slice_condition_config,
			                                     i_avs_writedata, i_avs_byteenable);
			s_nxt.slice_condition_config[pin_match_pkg::SLICE_LSB-1] = 1'b0;
			s_nxt.slice_clr = 1'b1;
		end

		// Edge flags, new edge wins over clear
		s_nxt.rise_flag = (s_r.rise_flag & ~rclr) | evt.rise;
		s_nxt.fall_flag = (s_r.fall_flag & ~fclr) | evt.fall;

		// Read data
		if (i_avs_read && s_r.waitreq) begin
			case (i_avs_address)
				pin_match_pkg::OFF_SENSE_MODE: s_nxt.rdata = {24'h000000, s_r.channel_sense_mode};
				pin_match_pkg::OFF_RISE_EN:    s_nxt.rdata = {24'h000000, s_r.rise_or_level_enable};
				pin_match_pkg::OFF_FALL_EN:
					s_nxt.rdata = {24'h000000, s_r.fall_or_level_polarity_enable};
				pin_match_pkg::OFF_RISE_FLAG:  s_nxt.rdata = {24'h000000, s_r.rise_flag};
				pin_match_pkg::OFF_FALL_FLAG:  s_nxt.rdata = {24'h000000, s_r.fall_flag};
				pin_match_pkg::OFF_STATUS:     s_nxt.rdata = {24'h000000, pin_req};
				pin_match_pkg::OFF_MATCH_CTRL:
					s_nxt.rdata = {det, 22'h000000, s_r.event_en, s_r.sel_match};
				pin_match_pkg::OFF_SLICE_SRC:  s_nxt.rdata = {s_r.slice_source_select, 8'h00};
				pin_match_pkg::OFF_SLICE_CFG:  s_nxt.rdata = s_r.slice_condition_config;
				default:                       s_nxt.rdata = pin_match_pkg::RST32;
			endcase
		end

		// Outputs
		s_nxt.irq       = s_r.sel_match ? term : pin_req;
		s_nxt.wake      = pin_req & {8{~s_r.sel_match}};
		s_nxt.rx_event  = s_r.event_en & (|term);
		s_nxt.match_pin = s_r.event_en & (|term);
	end

	//--------------------------------------------------
	// Registers
	//--------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s_r         <= '0;
			s_r.waitreq <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_avs_readdata      = s_r.rdata;
	assign o_avs_waitrequest   = s_r.waitreq;
	assign o_irq               = s_r.irq;
	assign o_wake              = s_r.wake;
	assign o_receive_event_out = s_r.rx_event;
	assign o_match_output_pin  = s_r.match_pin;

endmodule
`default_nettype wire

/* testbench/pin_match_engine_props.sv */
// Purpose: port checks of pin_match_engine
// Assumes: one clock, sync reset
// Notes:   bound to every instance
`timescale 1ns/100ps
`default_nettype none
module pin_match_engine_props #(
	parameter int N_IN = 8
) (
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic [7:0]  i_pins,
	input wire logic [5:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0]  i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic [7:0]  o_irq,
	input wire logic [7:0]  o_wake,
	input wire logic        o_receive_event_out,
	input wire logic        o_match_output_pin
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_quiet;
		($stable(i_pins) && !i_avs_write)[*6];
	endsequence
	sequence s_wo_read;
		i_avs_read && !o_avs_waitrequest && (i_avs_address inside {6'h08, 6'h0C, 6'h14, 6'h18}
			|| i_avs_address > 6'h30);
	endsequence
	property p_pin_same; o_match_output_pin == o_receive_event_out; endproperty
	property p_wait_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
	property p_wait_cause; $fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write); endproperty
	property p_idle_wait; !(i_avs_read || i_avs_write) |=> o_avs_waitrequest; endproperty
	property p_wake; o_wake != 8'h00 |-> o_wake == o_irq; endproperty
	property p_wo_zero; s_wo_read |-> o_avs_readdata == 32'h00000000; endproperty
	property p_rd_hold; !i_avs_read |=> $stable(o_avs_readdata); endproperty
	property p_quiet; s_quiet |=> $stable(o_irq); endproperty
	property p_reset;
		disable iff (1'b0) i_reset |=> o_avs_waitrequest && o_irq == 8'h00 && !o_receive_event_out;
	endproperty
	a_pin_same:   assert property (p_pin_same) else $error("match pin differs from event");
	a_wait_one:   assert property (p_wait_one) else $error("wait low too long");
	a_wait_cause: assert property (p_wait_cause) else $error("wait dropped without request");
	a_idle_wait:  assert property (p_idle_wait) else $error("wait low when idle");
	a_wake:       assert property (p_wake) else $error("wake not pin request");
	a_wo_zero:    assert property (p_wo_zero) else $error("write-only read not zero");
	a_rd_hold:    assert property (p_rd_hold) else $error("read data changed");
	a_quiet:      assert property (p_quiet) else $error("request changed with no cause");
	a_reset:      assert property (p_reset) else $error("outputs active after reset");
endmodule
bind pin_match_engine pin_match_engine_props #(.N_IN(N_IN)) u_props (.i_clk(i_clk), .i_reset(i_reset),
	.i_pins(i_pins), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq), .o_wake(o_wake),
	.o_receive_event_out(o_receive_event_out), .o_match_output_pin(o_match_output_pin));
`default_nettype wire

/* testbench/irq_sink.sv */
// Purpose: processor interrupt lines and event input
// Assumes: one clock
// Notes:   counts event rises
`timescale 1ns/100ps
`default_nettype none
module irq_sink (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic [7:0] i_irq,
	input  wire logic       i_event,
	output logic [31:0]     o_lines,
	output logic [7:0]      o_event_count
);
	logic event_r;
	assign o_lines = {i_irq, 24'h000000};
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			event_r <= 1'b0;
			o_event_count <= 8'h00;
		end else begin
			event_r <= i_event;
			if (i_event && !event_r) begin
				o_event_count <= o_event_count + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/test_pin_match_engine.sv */
// Purpose: self-checking bench of pin_match_engine
// Assumes: Avalon-MM master tasks
// Notes:   byteenable held at all lanes
`timescale 1ns/100ps
`default_nettype none
module test_pin_match_engine;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  pins = 8'h00;
	logic [5:0]  addr = 6'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic        waitreq;
	logic [7:0]  irq;
	logic [7:0]  wake;
	logic        receive_event_out;
	logic        mpin;
	logic [31:0] lines;
	logic [7:0]  ev_count;
	int          fail_count = 0;
	int          checks = 0;
	always #2 clk = ~clk;
	pin_match_engine dut (.i_clk(clk), .i_reset(reset), .i_pins(pins), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_irq(irq), .o_wake(wake),
		.o_receive_event_out(receive_event_out), .o_match_output_pin(mpin));
	irq_sink sink (.i_clk(clk), .i_reset(reset), .i_irq(irq), .i_event(receive_event_out), .o_lines(lines),
		.o_event_count(ev_count));
	task stop_test;
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (waitreq === 1'b0) break;
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n == 20) begin
			fail_count++;
			stop_test();
		end
	endtask
	task wr_reg(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd_chk(input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		check(q, exp);
	endtask
	task set_pins(input logic [7:0] v, input int n);
		@(posedge clk);
		pins <= v;
		repeat (n) @(posedge clk);
	endtask
	task t_regs;
		rd_chk(pin_match_pkg::OFF_SENSE_MODE, 32'h00000000);
		wr_reg(pin_match_pkg::OFF_SENSE_MODE, 32'h000000A5);
		rd_chk(pin_match_pkg::OFF_SENSE_MODE, 32'h000000A5);
		wr_reg(pin_match_pkg::OFF_SENSE_MODE, 32'h00000000);
		wr_reg(pin_match_pkg::OFF_RISE_EN_SET, 32'h00000003);
		wr_reg(pin_match_pkg::OFF_RISE_EN_CLR, 32'h00000002);
		rd_chk(pin_match_pkg::OFF_RISE_EN, 32'h00000001);
		rd_chk(pin_match_pkg::OFF_RISE_EN_SET, 32'h00000000);
		rd_chk(6'h3C, 32'h00000000);
	endtask
	task t_edge;
		set_pins(8'h09, 6);
		check(irq, 8'h01);
		check(lines, 32'h01000000);
		check(wake, 8'h01);
		rd_chk(pin_match_pkg::OFF_STATUS, 32'h00000001);
		rd_chk(pin_match_pkg::OFF_RISE_FLAG, 32'h00000009);
		wr_reg(pin_match_pkg::OFF_FALL_EN_SET, 32'h00000001);
		set_pins(8'h00, 6);
		rd_chk(pin_match_pkg::OFF_FALL_FLAG, 32'h00000009);
		wr_reg(pin_match_pkg::OFF_RISE_FLAG, 32'h00000009);
		wr_reg(pin_match_pkg::OFF_FALL_FLAG, 32'h00000009);
		repeat (3) @(posedge clk);
		check(irq, 8'h00);
	endtask
	task t_level;
		wr_reg(pin_match_pkg::OFF_SENSE_MODE, 32'h00000002);
		wr_reg(pin_match_pkg::OFF_RISE_EN_SET, 32'h00000002);
		wr_reg(pin_match_pkg::OFF_FALL_EN_SET, 32'h00000002);
		set_pins(8'h02, 6);
		check(irq, 8'h02);
		set_pins(8'h00, 6);
		check(irq, 8'h00);
		wr_reg(pin_match_pkg::OFF_FALL_EN_CLR, 32'h00000002);
		repeat (4) @(posedge clk);
		check(irq, 8'h02);
		wr_reg(pin_match_pkg::OFF_SENSE_MODE, 32'h00000000);
		wr_reg(pin_match_pkg::OFF_RISE_EN_CLR, 32'h000000FF);
		wr_reg(pin_match_pkg::OFF_FALL_EN_CLR, 32'h000000FF);
		repeat (3) @(posedge clk);
		check(irq, 8'h00);
	endtask
	task t_match;
		int n;
		n = 0;
		wr_reg(pin_match_pkg::OFF_SLICE_SRC, 32'h00008800);
		wr_reg(pin_match_pkg::OFF_SLICE_CFG, 32'hDB6DEC06);
		wr_reg(pin_match_pkg::OFF_MATCH_CTRL, 32'h00000003);
		set_pins(8'h01, 6);
		check(irq, 8'h02);
		check(receive_event_out, 1'b1);
		check(mpin, 1'b1);
		check(wake, 8'h00);
		rd_chk(pin_match_pkg::OFF_MATCH_CTRL, 32'h03000003);
		@(posedge clk);
		pins <= 8'h05;
		repeat (8) begin
			@(posedge clk);
			if (irq === 8'h06) n++;
		end
		check(n, 1);
		wr_reg(pin_match_pkg::OFF_MATCH_CTRL, 32'h00000002);
		repeat (3) @(posedge clk);
		check(irq, 8'h00);
		check(receive_event_out, 1'b1);
		wr_reg(pin_match_pkg::OFF_MATCH_CTRL, 32'h00000000);
		repeat (3) @(posedge clk);
		check(receive_event_out, 1'b0);
		check(ev_count, 8'h01);
	endtask
	task t_sticky;
		wr_reg(pin_match_pkg::OFF_SLICE_CFG, 32'hDB6DB101);
		wr_reg(pin_match_pkg::OFF_MATCH_CTRL, 32'h00000001);
		set_pins(8'h00, 6);
		check(irq, 8'h00);
		set_pins(8'h01, 6);
		check(irq, 8'h01);
		set_pins(8'h00, 6);
		check(irq, 8'h01);
		wr_reg(pin_match_pkg::OFF_SLICE_CFG, 32'hDB6DB101);
		repeat (4) @(posedge clk);
		check(irq, 8'h00);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_edge();
		t_level();
		t_match();
		t_sticky();
		stop_test();
	end
endmodule
`default_nettype wire
